// [rtl/ecpt_pkg.sv]
package ecpt_pkg;

   // ----------------------------------------------------------------
   // register map (byte-wide values sit in the low bits)
   // ----------------------------------------------------------------
   localparam logic [3:0] ECPT_ADDR_CTL0    = 4'h0;
   localparam logic [3:0] ECPT_ADDR_CTL1    = 4'h1;
   localparam logic [3:0] ECPT_ADDR_CTL2    = 4'h2;
   localparam logic [3:0] ECPT_ADDR_COUNT   = 4'h3;
   localparam logic [3:0] ECPT_ADDR_MATCH   = 4'h4;
   localparam logic [3:0] ECPT_ADDR_RELOAD  = 4'h5;
   localparam logic [3:0] ECPT_ADDR_STATUS  = 4'h6;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int ECPT_CTL1_RUN_BIT  = 7;
   localparam int ECPT_CTL1_POL_BIT  = 6;
   localparam int ECPT_CTL1_PRES_LSB = 3;
   localparam int ECPT_CTL1_MODE_LSB = 0;
   localparam int ECPT_CTL0_OUTEN_BIT = 0;
   localparam int ECPT_CTL2_CLKS_BIT  = 0;

   // ----------------------------------------------------------------
   // reset values and fixed counts
   // ----------------------------------------------------------------
   localparam logic [15:0] ECPT_COUNT_RESTART = 16'h0001;
   localparam logic [15:0] ECPT_COUNT_RESET   = 16'h0001;
   localparam logic [15:0] ECPT_RELOAD_RESET  = 16'hFFFF;
   localparam logic [15:0] ECPT_MATCH_RESET   = 16'h0000;
   localparam int          ECPT_SYNC_STAGES   = 2;

   // ----------------------------------------------------------------
   // operating modes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ECPT_MODE_PIN_COUNT = 3'h0,
      ECPT_MODE_CMP_COUNT = 3'h1,
      ECPT_MODE_PWM       = 3'h2
   } ecpt_mode_t;

   // software port
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } ecpt_bus_req_t;

   // timer configuration as decoded from the control registers
   typedef struct packed {
      logic       run;
      logic       pol;
      logic [2:0] pres;
      logic [2:0] mode;
      logic       outEn;
      logic       clkSel;
   } ecpt_cfg_t;

endpackage

// [rtl/ecpt_edge_sync.sv]
`timescale 1ns/10ps
// two-flop synchroniser plus edge qualifier for the count sources
module ecpt_edge_sync (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic reset,
   // source and selection
   input  wire logic srcIn,
   input  wire logic fallEdge,
   // qualified edge, one cycle
   output logic      edgePulse
);
   import ecpt_pkg::*;

   typedef struct packed {
      logic [ECPT_SYNC_STAGES-1:0] sync;
      logic                        last;
      logic                        pulse;
   } ecpt_sync_state_t;

   ecpt_sync_state_t state_q;
   ecpt_sync_state_t state_d;

   // first stage feeds only the second; edge taken from stage two vs last
   always_comb begin
      state_d       = state_q;
      state_d.sync  = {state_q.sync[0], srcIn};
      state_d.last  = state_q.sync[1];
      state_d.pulse = fallEdge ? (state_q.last & ~state_q.sync[1])
                               : (~state_q.last & state_q.sync[1]);
   end

   // register the whole state
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign edgePulse = state_q.pulse;

endmodule // ecpt_edge_sync

// [rtl/ecpt_timer.sv]
`timescale 1ns/10ps
// Contract
// - pin mode counts selected input edges
// - polarity bit picks rising or falling edge
// - pin mode bypasses the prescaler
// - counting reload: interrupt, count 0001h, continue
// - counting reload inverts enabled output
// - polarity bit sets initial output level
// - start count only for first pass
// - timer clock from control two select
// - count minus start equals edges seen
// - comparator mode counts comparator edges only
// - comparator mode edge select, no prescaler
// - PWM counts prescaled clocks, toggles on match
// - PWM reload: interrupt, 0001h, restore level
// - polarity one: high, low at match
// - polarity zero: low, high at match
// - period is reload times prescale clocks
// - configure disabled, start on enable write
// - run bit one starts, zero stops
module ecpt_timer #(
   parameter int CLK_DIV_ALT = 4   // divide ratio of the alternate timer clock
) (
   // clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   reset,
   // register port
   input  wire ecpt_pkg::ecpt_bus_req_t busReq,
   output logic [15:0]                 rdData,
   // count sources
   input  wire logic                   timerInPin,
   input  wire logic                   cmpOut,
   // outputs
   output logic                        timerOut,
   output logic                        timerIrq
);
   import ecpt_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  ctl0;
      logic [7:0]  ctl1;
      logic [7:0]  ctl2;
      logic [15:0] count;
      logic [15:0] match;
      logic [15:0] reload;
      logic [6:0]  preCnt;
      logic [15:0] divCnt;
      logic        outLvl;
      logic        outPin;
      logic        irq;
      logic        reloadSeen;
      logic [15:0] rd;
   } ecpt_state_t;

   ecpt_state_t state_q;
   ecpt_state_t state_d;
   ecpt_cfg_t   cfg;
   logic        pinEdge;
   logic        cmpEdge;
   logic        tick;
   logic        step;
   logic        atReload;
   logic [6:0]  preLimit;
   logic [15:0] divLimit;

   // ----------------------------------------------------------------
   // edge qualifiers; the fall/rise choice follows the polarity bit
   // ----------------------------------------------------------------
   ecpt_edge_sync u_pin_sync (
      .core_clk  (core_clk),
      .reset     (reset),
      .srcIn     (timerInPin),
      .fallEdge  (cfg.pol),
      .edgePulse (pinEdge)
   );

   ecpt_edge_sync u_cmp_sync (
      .core_clk  (core_clk),
      .reset     (reset),
      .srcIn     (cmpOut),
      .fallEdge  (cfg.pol),
      .edgePulse (cmpEdge)
   );

   // decode of the control registers
   always_comb begin
      cfg.run    = state_q.ctl1[ECPT_CTL1_RUN_BIT];
      cfg.pol    = state_q.ctl1[ECPT_CTL1_POL_BIT];
      cfg.pres   = state_q.ctl1[ECPT_CTL1_PRES_LSB +: 3];
      cfg.mode   = state_q.ctl1[ECPT_CTL1_MODE_LSB +: 3];
      cfg.outEn  = state_q.ctl0[ECPT_CTL0_OUTEN_BIT];
      cfg.clkSel = state_q.ctl2[ECPT_CTL2_CLKS_BIT];
   end

   // ----------------------------------------------------------------
   // timer clock enable and count step
   // ----------------------------------------------------------------
   // timer clock is core clock or a divided enable; edge inputs are sampled
   // on core clock, so the quarter-rate limit on sources keeps edges whole
   always_comb begin
      divLimit = 16'(CLK_DIV_ALT - 1);
      preLimit = 7'((8'h01 << cfg.pres) - 8'h01);
      tick     = cfg.clkSel ? (state_q.divCnt == divLimit) : 1'b1;
      unique case (cfg.mode)
         3'(ECPT_MODE_PIN_COUNT): step = pinEdge;
         3'(ECPT_MODE_CMP_COUNT): step = cmpEdge;
         3'(ECPT_MODE_PWM):       step = tick && (state_q.preCnt == preLimit);
         default:                 step = 1'b0;
      endcase
      step     = step & cfg.run;
      atReload = (state_q.count == state_q.reload);
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      state_d     = state_q;
      state_d.irq = 1'b0;
      state_d.rd  = 16'h0000;

      // alternate clock divider free-runs while control two selects it; with the core clock selected it holds zero
      if (tick) begin
         state_d.divCnt = 16'h0000;
      end else begin
         state_d.divCnt = state_q.divCnt + 16'h0001;
      end

      if (!cfg.run) begin
         // stopped: count holds, output shows the start level
         state_d.preCnt = 7'h00;
         state_d.outLvl = cfg.pol;
      end else if (cfg.mode == 3'(ECPT_MODE_PWM) && tick) begin
         state_d.preCnt = (state_q.preCnt == preLimit) ? 7'h00 : state_q.preCnt + 7'h01;
      end

      if (step) begin
         if (atReload) begin
            state_d.count      = ECPT_COUNT_RESTART;
            state_d.irq        = 1'b1;
            state_d.reloadSeen = 1'b1;
            if (cfg.mode == 3'(ECPT_MODE_PWM)) begin
               state_d.outLvl = cfg.pol;
            end else begin
               state_d.outLvl = ~state_q.outLvl;
            end
         end else begin
            state_d.count = state_q.count + 16'h0001;
            // toggle on leaving the match count, so the start level lasts match steps
            if (cfg.mode == 3'(ECPT_MODE_PWM) && (state_q.count == state_q.match)) begin
               state_d.outLvl = ~cfg.pol;
            end
         end
      end

      // pin drives only when the output function is enabled
      state_d.outPin = cfg.outEn ? state_d.outLvl : 1'b0;

      // register writes; value registers take effect while stopped
      if (busReq.wr) begin
         unique case (busReq.addr)
            ECPT_ADDR_CTL0:   state_d.ctl0 = busReq.wdata[7:0];
            ECPT_ADDR_CTL1: begin
               state_d.ctl1 = busReq.wdata[7:0];
               if (busReq.wdata[ECPT_CTL1_RUN_BIT] && !cfg.run) begin
                  state_d.reloadSeen = 1'b0;
               end
            end
            ECPT_ADDR_CTL2:   state_d.ctl2 = busReq.wdata[7:0];
            ECPT_ADDR_COUNT: begin
               if (!cfg.run) begin
                  state_d.count = busReq.wdata;
               end
            end
            ECPT_ADDR_MATCH: begin
               if (!cfg.run) begin
                  state_d.match = busReq.wdata;
               end
            end
            ECPT_ADDR_RELOAD: begin
               if (!cfg.run) begin
                  state_d.reload = busReq.wdata;
               end
            end
            default: ;
         endcase
      end

      // register reads, answered the next cycle; unmapped reads zero
      if (busReq.rd) begin
         unique case (busReq.addr)
            ECPT_ADDR_CTL0:   state_d.rd = {8'h00, state_q.ctl0};
            ECPT_ADDR_CTL1:   state_d.rd = {8'h00, state_q.ctl1};
            ECPT_ADDR_CTL2:   state_d.rd = {8'h00, state_q.ctl2};
            ECPT_ADDR_COUNT:  state_d.rd = state_q.count;
            ECPT_ADDR_MATCH:  state_d.rd = state_q.match;
            ECPT_ADDR_RELOAD: state_d.rd = state_q.reload;
            ECPT_ADDR_STATUS: state_d.rd = {14'h0000, state_q.reloadSeen, state_q.outLvl};
            default:          state_d.rd = 16'h0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q        <= '0;
         state_q.count  <= ECPT_COUNT_RESET;
         state_q.match  <= ECPT_MATCH_RESET;
         state_q.reload <= ECPT_RELOAD_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   // outputs straight from flops
   assign rdData   = state_q.rd;
   assign timerOut = state_q.outPin;
   assign timerIrq = state_q.irq;

endmodule // ecpt_timer

// [sim/ecpt_timer_checker.sv]
`timescale 1ns/10ps
// ------------------------------
// timer port checks
// ------------------------------
module ecpt_timer_checker (
   // clock and reset
   input wire logic                    core_clk,
   input wire logic                    reset,
   // register port
   input wire ecpt_pkg::ecpt_bus_req_t busReq,
   input wire logic [15:0]             rdData,
   // pins
   input wire logic                    timerInPin,
   input wire logic                    cmpOut,
   input wire logic                    timerOut,
   input wire logic                    timerIrq
);
   import ecpt_pkg::*;
   logic [7:0] pinH_q, cmpH_q;
   logic [2:0] mode_q;
   logic       run_q, pol_q, outEn_q;
   logic [1:0] still_q;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // control shadow; still_q waits out the output register after a write
   always_ff @(posedge core_clk) begin
      pinH_q  <= {pinH_q[6:0], timerInPin};
      cmpH_q  <= {cmpH_q[6:0], cmpOut};
      still_q <= (reset || (busReq.wr && busReq.addr < 4'h2)) ? 2'h0 : still_q + 2'(still_q != 2'h3);
      if (reset) begin
         {run_q, pol_q, mode_q, outEn_q} <= '0;
      end else if (busReq.wr && busReq.addr == ECPT_ADDR_CTL1) begin
         {run_q, pol_q, mode_q} <= {busReq.wdata[7:6], busReq.wdata[2:0]};
      end else if (busReq.wr && busReq.addr == ECPT_ADDR_CTL0) begin
         outEn_q <= busReq.wdata[0];
      end
   end
   property p_pulse; timerIrq |=> !timerIrq; endproperty
   a_pulse: assert property (p_pulse) else $error("irq too long");
   property p_quiet; !run_q [*3] |-> !timerIrq; endproperty
   a_quiet: assert property (p_quiet) else $error("irq while stopped");
   property p_idle; still_q == 2'h3 && !run_q |-> timerOut == (outEn_q & pol_q); endproperty
   a_idle: assert property (p_idle) else $error("stopped level");
   property p_off; still_q == 2'h3 && !outEn_q |-> !timerOut; endproperty
   a_off: assert property (p_off) else $error("output not off");
   property p_flip; timerIrq && outEn_q && mode_q != 3'h2 |-> timerOut != $past(timerOut); endproperty
   a_flip: assert property (p_flip) else $error("no toggle at reload");
   property p_pwm; timerIrq && outEn_q && mode_q == 3'h2 |-> timerOut == pol_q; endproperty
   a_pwm: assert property (p_pwm) else $error("pwm level at reload");
   property p_pin; timerIrq && mode_q == 3'h0 |-> pinH_q != 8'h00 && pinH_q != 8'hFF; endproperty
   a_pin: assert property (p_pin) else $error("count without pin edge");
   property p_cmp; timerIrq && mode_q == 3'h1 |-> cmpH_q != 8'h00 && cmpH_q != 8'hFF; endproperty
   a_cmp: assert property (p_cmp) else $error("count without comparator edge");
   // one reload seen in each mode
   c_pin: cover property (timerIrq && mode_q == 3'h0);
   c_cmp: cover property (timerIrq && mode_q == 3'h1);
   c_pwm: cover property (timerIrq && mode_q == 3'h2);
endmodule // ecpt_timer_checker
bind ecpt_timer ecpt_timer_checker chk_u (.core_clk, .reset, .busReq, .rdData, .timerInPin, .cmpOut, .timerOut, .timerIrq);

// [sim/ecpt_src_model.sv]
`timescale 1ns/10ps
// pin and comparator source; levels held at least four cycles each
module ecpt_src_model (
   // clock
   input wire logic core_clk,
   // source levels
   output logic     pinLvl,
   output logic     cmpLvl
);
   initial begin
      pinLvl = 1'b0;
      cmpLvl = 1'b0;
   end
   // n level changes, hold cycles apart but never under four; faster would alias in the sampler
   task automatic wiggle(input bit useCmp, input int n, input int hold);
      repeat (n) begin
         @(posedge core_clk);
         if (useCmp) begin
            cmpLvl <= ~cmpLvl;
         end else begin
            pinLvl <= ~pinLvl;
         end
         repeat ((hold < 4) ? 3 : hold - 1) @(posedge core_clk);
      end
   endtask
endmodule // ecpt_src_model

// [sim/ecpt_timer_test.sv]
`timescale 1ns/10ps
// ------------------------------
// timer bench
// ------------------------------
module ecpt_timer_test;
   import ecpt_pkg::*;
   localparam int DIV = 2;
   logic          core_clk = 1'b0;
   logic          reset = 1'b1;
   ecpt_bus_req_t busReq = '0;
   logic [15:0]   rdData;
   logic          timerInPin, cmpOut, timerOut, timerIrq;
   int            failures = 0, nChecks = 0, irqCnt = 0;
   ecpt_timer #(.CLK_DIV_ALT(DIV)) dut_u (.core_clk, .reset, .busReq, .rdData, .timerInPin, .cmpOut, .timerOut, .timerIrq);
   ecpt_src_model src_u (.core_clk(core_clk), .pinLvl(timerInPin), .cmpLvl(cmpOut));
   always #20 core_clk = ~core_clk;
   // reload pulses tallied as they pass
   always @(posedge core_clk) irqCnt <= irqCnt + int'(timerIrq === 1'b1);
   task automatic test_done();
      if (failures == 0 && nChecks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      nChecks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      busReq.wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      busReq.rd <= 1'b0;
      #1;
      chk(rdData, exp);
   endtask
   // cycles between two reloads, and how many of them had the output high
   task automatic measure(output logic [15:0] per, output logic [15:0] high);
      per = 16'h0000;
      high = 16'h0000;
      do begin
         @(posedge core_clk);
         #1;
         per++;
      end while (timerIrq !== 1'b1 && per < 16'd400);
      per = 16'h0000;
      do begin
         high += 16'(timerOut === 1'b1);
         @(posedge core_clk);
         #1;
         per++;
      end while (timerIrq !== 1'b1 && per < 16'd400);
   endtask
   task automatic t_reset();
      rdc(4'h1, 16'h0000);
      rdc(4'h3, ECPT_COUNT_RESET);
      rdc(4'h5, ECPT_RELOAD_RESET);
      rdc(4'hF, 16'h0000);
   endtask
   // rising edges, prescale 7 ignored, count write refused while running
   task automatic t_pin();
      wr(4'h1, 16'h0038);
      wr(4'h0, 16'h0001);
      wr(4'h3, 16'h0005);
      wr(4'h5, 16'h0008);
      chk(16'(timerOut), 16'h0000);
      wr(4'h1, 16'h00B8);
      wr(4'h3, 16'h00AA);
      src_u.wiggle(1'b0, 3, 3);
      repeat (6) @(posedge core_clk);
      wr(4'h1, 16'h0038);
      rdc(4'h3, 16'h0007);
      wr(4'h1, 16'h00B8);
      src_u.wiggle(1'b0, 6, 3);
      repeat (6) @(posedge core_clk);
      chk(16'(timerOut), 16'h0001);
      wr(4'h1, 16'h0038);
      src_u.wiggle(1'b0, 2, 3);
      rdc(4'h3, 16'h0002);
      rdc(4'h6, 16'h0002);
      chk(16'(irqCnt), 16'h0001);
   endtask
   // falling comparator edges only; pin activity must not count
   task automatic t_cmp();
      wr(4'h1, 16'h0079);
      wr(4'h3, 16'h0001);
      wr(4'h5, 16'h0002);
      chk(16'(timerOut), 16'h0001);
      wr(4'h1, 16'h00F9);
      src_u.wiggle(1'b0, 2, 3);
      src_u.wiggle(1'b1, 5, 3);
      repeat (6) @(posedge core_clk);
      chk(16'(timerOut), 16'h0000);
      wr(4'h1, 16'h0079);
      rdc(4'h3, 16'h0001);
      chk(16'(irqCnt), 16'h0002);
   endtask
   // period and high time for both polarities, a prescale and the slow clock
   task automatic t_pwm();
      logic [15:0] ctl, k, per, high;
      for (int i = 0; i < 3; i++) begin
         ctl = 16'h0002 | (16'(i == 1) << 6) | (16'(i % 2) << 3);
         k = 16'((1 << (i % 2)) * ((i == 2) ? DIV : 1));
         wr(4'h1, ctl);
         wr(4'h2, 16'(i == 2));
         wr(4'h4, 16'h0002);
         rdc(4'h4, 16'h0002);
         wr(4'h5, 16'h0006);
         wr(4'h1, ctl | 16'h0080);
         measure(per, high);
         chk(per, 16'h0006 * k);
         chk(high, ((i == 1) ? 16'h0002 : 16'h0004) * k);
         wr(4'h1, ctl);
      end
   endtask
   initial begin
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      t_reset();
      t_pin();
      t_cmp();
      t_pwm();
      test_done();
   end
   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      test_done();
   end
endmodule // ecpt_timer_test
